// ### core/isc_pkg.sv
package isc_pkg;
  localparam int NSRC = 6;
  localparam int NPIN = 8;
  localparam int NTMR = 4;
  localparam int T16_IDX = 0;
  localparam int TM2_IDX = 1;
  localparam int TM3_IDX = 2;
  localparam logic [15:0] VEC_ADDR = 16'h0010;
  localparam logic [7:0] SP_STEP = 8'h02;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [4:0] WAKE_NORMAL = 5'h10;
  localparam logic [4:0] WAKE_FAST = 5'h08;
  localparam logic [5:0] REG_REQ = 6'h00;
  localparam logic [5:0] REG_EN = 6'h04;
  localparam logic [5:0] REG_EDGE = 6'h08;
  localparam logic [5:0] REG_SP = 6'h0c;
  localparam logic [5:0] REG_CLK = 6'h10;
  localparam logic [5:0] REG_WAKE = 6'h14;
  localparam logic [5:0] REG_PDIR = 6'h18;
  localparam logic [5:0] REG_PDIE = 6'h1c;
  localparam logic [5:0] REG_STAT = 6'h20;
  localparam logic [11:0] EDGE_RST = 12'h555;
  localparam logic [1:0] CLK_RST = 2'h3;
  localparam logic [3:0] WAKE_RST = 4'h0;
  localparam int CLK_HS = 0;
  localparam int CLK_LS = 1;
  localparam int WK_NANO = 0;
  localparam int WK_FAST = 1;
  localparam int WK_CMPEN = 2;
  localparam int WK_CMPWK = 3;
  localparam logic [1:0] TSRC_SYS = 2'h0;
  localparam logic [1:0] TSRC_HS = 2'h1;
  localparam logic [1:0] TSRC_LS = 2'h2;
  localparam logic [1:0] TSRC_NANO = 2'h3;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0, ST_RDW = 3'h1, ST_CAP = 3'h3,
    ST_SAVE = 3'h4, ST_WAKE = 3'h6, ST_DOWN = 3'h5
  } isc_state_e;
  typedef enum logic [2:0] {
    OP_NONE, OP_EN, OP_DIS, OP_RETI, OP_PUSH, OP_POP, OP_EXE, OP_SYS
  } isc_op_e;
  typedef struct packed {
    logic boundary; logic engint; logic disgint; logic reti;
    logic pushaf; logic popaf; logic stopexe; logic stopsys;
    logic [15:0] pc; logic [7:0] accumulator; logic [7:0] flags;
  } isc_cpu_req_s;
  typedef struct packed {
    logic halt; logic pc_load; logic [15:0] pc_value;
    logic acc_load; logic [7:0] accumulator; logic [7:0] flags;
  } isc_cpu_resp_s;
  typedef struct packed {
    logic we; logic re; logic [7:0] addr; logic [15:0] wdata;
  } isc_mem_s;
  typedef struct packed {
    logic high_speed_rc_osc; logic low_speed_rc_osc;
    logic nano_low_rc_osc; logic sysclk_en;
  } isc_osc_s;
endpackage

// ### core/isc_top.sv
`timescale 1ns/1ns
// How it works
// - Six sources, each with its enable bit.
// - Hardware sets flags; register write clears them.
// - Flag set on chosen rising/falling/both edge.
// - Flags set even when enable bit zero.
// - Global enable gates all lines together.
// - Entry pushes PC at pointer, pointer plus two.
// - Entry clears global enable, jumps to vector.
// - Return pops PC, pointer minus two, enables.
// - Push/pop save accumulator and flags on stack.
// - Three modes: on, power-save, power-down.
// - Power-down stops fast and slow RC.
// - Power-save gates only the system clock.
// - Sleeping timers stop on sysclk or dead osc.
// - Power-save wakes on enabled input pin toggle.
// - Power-save wakes on non-sysclk timer match.
// - Eight-bit timer wake needs nano oscillator.
// - Comparator wake needs both comparator bits.
// - Power-down wakes on pin or eight-bit nano timer.
// - Memory and registers kept through power-down.
// - Pin wake resumes after sleep, no reset.
// - Wake takes sixteen or eight slow clocks.
module isc_top
  import isc_pkg::*;
#(
  parameter int NPIN_P = NPIN
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire isc_cpu_req_s cpu_req,
  output isc_cpu_resp_s cpu_resp,
  output isc_mem_s mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic [NSRC-1:0] src_in,
  input wire logic [NPIN_P-1:0] pin_in,
  input wire logic low_rc_clk_in,
  input wire logic [NTMR-1:0][1:0] timer_src,
  input wire logic [NTMR-1:0] timer_hit,
  input wire logic cmp_hit,
  output isc_osc_s osc_ctl,
  output logic [NTMR-1:0] timer_run
);

  function automatic logic sel(input logic [5:0] a, input logic [5:0] off);
    return {a[5:2], 2'h0} == off;
  endfunction

  function automatic isc_op_e decode_op(input isc_cpu_req_s r);
    if (r.stopsys) return OP_SYS;
    if (r.stopexe) return OP_EXE;
    if (r.reti) return OP_RETI;
    if (r.popaf) return OP_POP;
    if (r.pushaf) return OP_PUSH;
    if (r.engint) return OP_EN;
    if (r.disgint) return OP_DIS;
    return OP_NONE;
  endfunction

  function automatic logic clk_on(input logic [1:0] s, input isc_osc_s o);
    case (s)
      TSRC_SYS: return o.sysclk_en;
      TSRC_HS: return o.high_speed_rc_osc;
      TSRC_LS: return o.low_speed_rc_osc;
      default: return o.nano_low_rc_osc;
    endcase
  endfunction

  logic ext_s1, ext_s2, ls_s1, ls_s2, ls_prev;
  logic [NPIN_P-1:0] pin_s1, pin_s2, pin_prev, pin_dir, pin_die;
  logic [NSRC-1:0] src_now, src_prev, set_evt, req, int_en;
  logic [2*NSRC-1:0] edge_sel;
  logic [1:0] clk_cfg;
  logic [3:0] wake_cfg;
  logic [7:0] stack_pointer;
  logic gie, pop_pc, was_down, take_irq, exec, bus_wr, wake_done;
  logic wk_save, wk_down, ls_rise, deep;
  logic [NTMR-1:0] hit_save, hit_down;
  logic [4:0] wake_cnt, wake_target;
  logic [31:0] rd_mux;
  isc_state_e st, next_st;
  isc_op_e op;
  isc_osc_s next_osc;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////
  // The external pin, the input pins and the slow RC clock are asynchronous.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_s1 <= 1'h0;
      ext_s2 <= 1'h0;
      ls_s1 <= 1'h0;
      ls_s2 <= 1'h0;
      ls_prev <= 1'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_prev <= '0;
      src_prev <= '0;
    end else begin
      ext_s1 <= src_in[0];
      ext_s2 <= ext_s1;
      ls_s1 <= low_rc_clk_in;
      ls_s2 <= ls_s1;
      ls_prev <= ls_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
      src_prev <= src_now;
    end
  end

  assign src_now = {src_in[NSRC-1:1], ext_s2};
  assign ls_rise = ls_s2 & ~ls_prev;

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_edge
      assign set_evt[gi] = (src_now[gi] & ~src_prev[gi] & edge_sel[2*gi]) |
                           (~src_now[gi] & src_prev[gi] & edge_sel[2*gi+1]);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave: every access waits exactly one cycle.
  assign bus_wr = avs_write & ~avs_waitrequest;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'h1;
      avs_readdata <= 32'h0;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'h0;
      avs_readdata <= avs_read ? rd_mux : 32'h0;
    end else begin
      avs_waitrequest <= 1'h1;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (sel(avs_address, REG_REQ)) rd_mux = 32'(req);
    else if (sel(avs_address, REG_EN)) rd_mux = 32'(int_en);
    else if (sel(avs_address, REG_EDGE)) rd_mux = 32'(edge_sel);
    else if (sel(avs_address, REG_SP)) rd_mux = 32'(stack_pointer);
    else if (sel(avs_address, REG_CLK)) rd_mux = 32'(clk_cfg);
    else if (sel(avs_address, REG_WAKE)) rd_mux = 32'(wake_cfg);
    else if (sel(avs_address, REG_PDIR)) rd_mux = 32'(pin_dir);
    else if (sel(avs_address, REG_PDIE)) rd_mux = 32'(pin_die);
    else if (sel(avs_address, REG_STAT)) rd_mux = 32'({st, gie});
  end

  //////////////////////////////////////////////////////////////////////////
  // A write keeps flags written as one; a new event in the same cycle wins.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) req <= '0;
    else if (bus_wr && sel(avs_address, REG_REQ))
      req <= (req & avs_writedata[NSRC-1:0]) | set_evt;
    else req <= req | set_evt;
  end

  // Nothing here depends on the power mode, so settings survive sleep.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_en <= '0;
      edge_sel <= EDGE_RST;
      clk_cfg <= CLK_RST;
      wake_cfg <= WAKE_RST;
      pin_dir <= '0;
      pin_die <= '0;
    end else if (bus_wr) begin
      if (sel(avs_address, REG_EN)) int_en <= avs_writedata[NSRC-1:0];
      if (sel(avs_address, REG_EDGE)) edge_sel <= avs_writedata[2*NSRC-1:0];
      if (sel(avs_address, REG_CLK)) clk_cfg <= avs_writedata[1:0];
      if (sel(avs_address, REG_WAKE)) wake_cfg <= avs_writedata[3:0];
      if (sel(avs_address, REG_PDIR)) pin_dir <= avs_writedata[NPIN_P-1:0];
      if (sel(avs_address, REG_PDIE)) pin_die <= avs_writedata[NPIN_P-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Instruction handling at the boundary; a pending interrupt pre-empts it.
  assign exec = (st == ST_RUN) & cpu_req.boundary;
  assign take_irq = exec & gie & |(req & int_en);
  assign op = (exec & ~take_irq) ? decode_op(cpu_req) : OP_NONE;

  a_take_jump: assert property (exec && gie && |(req & int_en) |=>
    cpu_resp.pc_load && cpu_resp.pc_value == VEC_ADDR && cpu_resp.halt)
    else $error("pending enabled interrupt not taken");
  a_gie_fall: assert property ($fell(gie) |-> $past(take_irq) ||
    $past(op) == OP_DIS) else $error("global enable dropped without cause");

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) gie <= 1'h0;
    else if (take_irq) gie <= 1'h0;
    else if (st == ST_CAP && pop_pc) gie <= 1'h1;
    else if (op == OP_EN) gie <= 1'h1;
    else if (op == OP_DIS) gie <= 1'h0;
  end

  // Bit zero is never forced: keeping it clear is up to software.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) stack_pointer <= SP_RST;
    else if (bus_wr && sel(avs_address, REG_SP)) stack_pointer <= avs_writedata[7:0];
    else if (take_irq || op == OP_PUSH) stack_pointer <= stack_pointer + SP_STEP;
    else if (op == OP_RETI || op == OP_POP) stack_pointer <= stack_pointer - SP_STEP;
  end

  a_entry_push: assert property (take_irq |=> mem_cmd.we &&
    mem_cmd.addr == $past(stack_pointer) && mem_cmd.wdata == $past(cpu_req.pc) &&
    stack_pointer == 8'($past(stack_pointer) + SP_STEP))
    else $error("entry did not push the program counter");
  a_entry_gie: assert property (take_irq |=> !gie ##1 !gie || $past(op) == OP_EN)
    else $error("global enable not cleared on entry");
  a_reti_pop: assert property (op == OP_RETI |=> mem_cmd.re &&
    mem_cmd.addr == 8'($past(stack_pointer) - SP_STEP) ##2 cpu_resp.pc_load && gie ##1 !cpu_resp.halt)
    else $error("return did not restore the program counter");
  a_push_af: assert property (op == OP_PUSH |=> mem_cmd.we &&
    mem_cmd.wdata == {$past(cpu_req.flags), $past(cpu_req.accumulator)})
    else $error("accumulator push wrong");

  //////////////////////////////////////////////////////////////////////////
  // Wake sources, qualified per mode.
  generate
    for (gi = 0; gi < NTMR; gi++) begin : g_wake
      localparam bit IS_TM8 = (gi == TM2_IDX) || (gi == TM3_IDX);
      logic nano_ok;
      assign nano_ok = wake_cfg[WK_NANO] & (timer_src[gi] == TSRC_NANO);
      assign hit_save[gi] = timer_hit[gi] & (IS_TM8 ? nano_ok : timer_src[gi] != TSRC_SYS);
      assign hit_down[gi] = timer_hit[gi] & IS_TM8 & nano_ok;
    end
  endgenerate

  assign wk_save = |((pin_s2 ^ pin_prev) & pin_dir & pin_die) | |hit_save |
                   (cmp_hit & wake_cfg[WK_CMPEN] & wake_cfg[WK_CMPWK]);
  assign wk_down = |((pin_s2 ^ pin_prev) & pin_die) | |hit_down;

  assign wake_target = wake_cfg[WK_FAST] ? WAKE_FAST : WAKE_NORMAL;
  assign wake_done = (st == ST_WAKE) && (wake_cnt == wake_target);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) wake_cnt <= 5'h0;
    else if (st != ST_WAKE) wake_cnt <= 5'h0;
    else if (ls_rise && !wake_done) wake_cnt <= wake_cnt + 5'h1;
  end

  a_wake_len: assert property (st == ST_WAKE && wake_cnt == wake_target |=> st == ST_RUN)
    else $error("wake did not end at target count");
  a_wake_early: assert property (st == ST_WAKE && wake_cnt != wake_target |=>
    st == ST_WAKE) else $error("wake ended early");
  a_down_hold: assert property (st == ST_DOWN && !wk_down |=> st == ST_DOWN)
    else $error("power-down left without a wake source");

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencer.
  always_comb begin
    next_st = st;
    case (st)
      ST_RUN: begin
        if (op == OP_RETI || op == OP_POP) next_st = ST_RDW;
        else if (op == OP_EXE) next_st = ST_SAVE;
        else if (op == OP_SYS) next_st = ST_DOWN;
      end
      ST_RDW: next_st = ST_CAP;
      ST_CAP: next_st = ST_RUN;
      ST_SAVE: next_st = wk_save ? ST_WAKE : ST_SAVE;
      ST_DOWN: next_st = wk_down ? ST_WAKE : ST_DOWN;
      ST_WAKE: next_st = wake_done ? ST_RUN : ST_WAKE;
      default: next_st = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) st <= ST_RUN;
    else st <= next_st;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pop_pc <= 1'h0;
      was_down <= 1'h0;
    end else begin
      if (op == OP_RETI) pop_pc <= 1'h1;
      else if (op == OP_POP) pop_pc <= 1'h0;
      if (op == OP_SYS) was_down <= 1'h1;
      else if (op == OP_EXE) was_down <= 1'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // CPU and data memory side. The program counter is untouched by a wake,
  // so the core simply continues after the sleep instruction.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cpu_resp <= '0;
      mem_cmd <= '0;
    end else begin
      cpu_resp.halt <= (next_st != ST_RUN) | take_irq | (st == ST_CAP);
      cpu_resp.pc_load <= take_irq | (st == ST_CAP && pop_pc);
      cpu_resp.acc_load <= st == ST_CAP && !pop_pc;
      mem_cmd.we <= take_irq | (op == OP_PUSH);
      mem_cmd.re <= (op == OP_RETI) | (op == OP_POP);
      if (take_irq) cpu_resp.pc_value <= VEC_ADDR;
      else if (st == ST_CAP && pop_pc) cpu_resp.pc_value <= mem_rdata;
      if (st == ST_CAP && !pop_pc) begin
        cpu_resp.accumulator <= mem_rdata[7:0];
        cpu_resp.flags <= mem_rdata[15:8];
      end
      if (take_irq) begin
        mem_cmd.addr <= stack_pointer;
        mem_cmd.wdata <= cpu_req.pc;
      end else if (op == OP_PUSH) begin
        mem_cmd.addr <= stack_pointer;
        mem_cmd.wdata <= {cpu_req.flags, cpu_req.accumulator};
      end else if (op == OP_RETI || op == OP_POP) begin
        mem_cmd.addr <= stack_pointer - SP_STEP;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // The fast RC stays off through a wake from power-down, unlike the slow RC,
  // which the wake counter needs as its time base.
  assign deep = (next_st == ST_DOWN) | ((next_st == ST_WAKE) & was_down);

  always_comb begin
    next_osc.high_speed_rc_osc = clk_cfg[CLK_HS] & ~deep;
    next_osc.low_speed_rc_osc = (clk_cfg[CLK_LS] & ~deep) | (next_st == ST_WAKE);
    next_osc.nano_low_rc_osc = wake_cfg[WK_NANO];
    next_osc.sysclk_en = (next_st == ST_RUN) | (next_st == ST_RDW) | (next_st == ST_CAP);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      osc_ctl <= '0;
      timer_run <= '0;
    end else begin
      osc_ctl <= next_osc;
      for (int i = 0; i < NTMR; i++) timer_run[i] <= clk_on(timer_src[i], next_osc);
    end
  end

  a_save_clock: assert property (st == ST_SAVE && $past(st) == ST_SAVE |->
    !osc_ctl.sysclk_en && osc_ctl.high_speed_rc_osc == $past(clk_cfg[CLK_HS]))
    else $error("power-save clock gating wrong");
  a_down_osc: assert property (st == ST_DOWN |-> !osc_ctl.high_speed_rc_osc &&
    !osc_ctl.low_speed_rc_osc) else $error("oscillator running in power-down");
  a_timer_stop: assert property (st == ST_SAVE && $past(st) == ST_SAVE &&
    $past(timer_src[TM2_IDX]) == TSRC_SYS |-> !timer_run[TM2_IDX])
    else $error("sysclk timer runs in power-save");
  a_set_wins: assert property (bus_wr && sel(avs_address, REG_REQ) && set_evt[0] |=> req[0])
    else $error("event lost under a clear");
  a_flag_noen: assert property (set_evt[2] && !int_en[2] |=> req[2])
    else $error("flag not set while disabled");
  a_edge_rise: assert property (edge_sel[1:0] == 2'h1 && !req[0] &&
    !src_now[0] && src_prev[0] |=> !req[0]) else $error("falling edge set a rising-only flag");

  c_take: cover property (take_irq ##1 cpu_resp.pc_load);
  c_reti: cover property (op == OP_RETI ##3 cpu_resp.pc_load);
  c_save_wake: cover property (st == ST_SAVE ##1 st == ST_WAKE);
  c_down_wake: cover property (st == ST_DOWN ##1 st == ST_WAKE);

endmodule

// ### sim/isc_partner.sv
`timescale 1ns/1ns
module isc_partner
  import isc_pkg::*;
(
  input wire logic core_clk,
  input wire isc_mem_s mem_cmd,
  input wire logic ls_en,
  output logic [15:0] mem_rdata,
  output logic low_rc_clk_in
);
  logic [15:0] stack_mem [256];
  // Read data is valid only in the cycle after a read; elsewhere it toggles so a late sample shows.
  always @(posedge core_clk) begin
    if (mem_cmd.re) begin
      mem_rdata <= stack_mem[mem_cmd.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_cmd.we) begin
      stack_mem[mem_cmd.addr] <= mem_cmd.wdata;
    end
  end
  // The slow RC runs at 10 MHz with its own phase, and only while the block keeps it enabled.
  initial begin
    low_rc_clk_in = 1'b0;
    #37;
    forever begin
      #50;
      if (ls_en === 1'b1) low_rc_clk_in = ~low_rc_clk_in;
    end
  end
endmodule

// ### sim/isc_top_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module isc_top_test;
  import isc_pkg::*;
  logic core_clk, reset, avs_read, avs_write, avs_waitrequest, low_rc_clk_in, cmp_hit;
  logic [5:0] avs_address;
  logic [5:0] src_in;
  logic [31:0] avs_writedata, avs_readdata, rdq;
  logic [15:0] mem_rdata;
  logic [7:0] pin_in;
  logic [3:0][1:0] timer_src;
  logic [3:0] timer_hit, timer_run;
  isc_cpu_req_s cpu_req;
  isc_cpu_resp_s cpu_resp, s_resp;
  isc_mem_s mem_cmd, s_mem;
  isc_osc_s osc_ctl;
  int error_cnt = 0;
  int n_compared = 0;
  isc_top i_dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_resp(cpu_resp), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .src_in(src_in), .pin_in(pin_in), .low_rc_clk_in(low_rc_clk_in),
    .timer_src(timer_src), .timer_hit(timer_hit), .cmp_hit(cmp_hit), .osc_ctl(osc_ctl),
    .timer_run(timer_run));
  isc_partner i_partner (.core_clk(core_clk), .mem_cmd(mem_cmd), .ls_en(osc_ctl.low_speed_rc_osc),
    .mem_rdata(mem_rdata), .low_rc_clk_in(low_rc_clk_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Ops are {engint, disgint, reti, pushaf, popaf, stopexe, stopsys}; offered for one boundary.
  task automatic cpu(input logic [6:0] ops, input logic [15:0] pc);
    @(posedge core_clk);
    while (cpu_resp.halt !== 1'b0) @(posedge core_clk);
    cpu_req <= {1'b1, ops, pc, 8'h5a, 8'ha5};
    @(posedge core_clk);
    cpu_req <= '0;
  endtask
  // Snapshot of the answer at the edge where the chosen pulse is seen: 0 pc_load, 1 acc_load, 2 mem we.
  task automatic grab(input int which);
    for (int n = 0; n < 12; n++) begin
      @(posedge core_clk);
      s_resp = cpu_resp;
      s_mem = mem_cmd;
      if ((which == 0 && s_resp.pc_load === 1'b1) || (which == 1 && s_resp.acc_load === 1'b1) ||
          (which == 2 && s_mem.we === 1'b1)) return;
    end
    `CHK("answer pulse", 1'b1, 1'b0)
  endtask
  task automatic wake_span(input int lo, input int hi);
    repeat (lo) @(posedge core_clk);
    `CHK("halt while waking", 1'b1, cpu_resp.halt)
    for (int n = 0; n < hi && cpu_resp.halt !== 1'b0; n++) @(posedge core_clk);
    `CHK("halt after wake", 1'b0, cpu_resp.halt)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(0, REG_EDGE, 0);
    `CHK("edge select", 32'h555, rdq)
    bus(0, REG_CLK, 0);
    `CHK("clock cfg", 32'h3, rdq)
    bus(0, REG_WAKE, 0);
    `CHK("wake cfg", 32'h0, rdq)
    bus(0, REG_STAT, 0);
    `CHK("status", 32'h0, rdq)
    bus(0, 6'h3c, 0);
    `CHK("unmapped", 32'h0, rdq)
    $display("test regs done");
  endtask
  task automatic t_flags;
    src_in[1] <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, REG_REQ, 0);
    `CHK("flag disabled src", 32'h02, rdq)
    bus(1, REG_EDGE, 32'h559);
    // The synchronised pin edge reaches the flag at the very edge the clear lands.
    src_in[0] <= 1'b1;
    bus(1, REG_REQ, 0);
    bus(0, REG_REQ, 0);
    `CHK("clear, new event wins", 32'h01, rdq)
    src_in[1] <= 1'b0;
    src_in[2] <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, REG_REQ, 0);
    `CHK("falling and rising", 32'h07, rdq)
    bus(1, REG_REQ, 32'h3c);
    src_in[0] <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus(0, REG_REQ, 0);
    `CHK("single clear, no fall", 32'h04, rdq)
    $display("test flags done");
  endtask
  task automatic t_irq;
    bus(1, REG_SP, 32'h20);
    bus(1, REG_EN, 32'h04);
    cpu(7'h00, 16'h0100);
    repeat (4) @(posedge core_clk);
    `CHK("no take, global off", 1'b0, cpu_resp.halt)
    cpu(7'h40, 16'h0101);
    cpu(7'h00, 16'h1234);
    grab(0);
    `CHK("vector", VEC_ADDR, s_resp.pc_value)
    `CHK("push addr", 8'h20, s_mem.addr)
    `CHK("push pc", 16'h1234, s_mem.wdata)
    bus(0, REG_SP, 0);
    `CHK("sp up", 32'h22, rdq)
    bus(0, REG_STAT, 0);
    `CHK("gie off", 1'b0, rdq[0])
    bus(1, REG_REQ, 0);
    cpu(7'h10, 16'h0011);
    grab(0);
    `CHK("return pc", 16'h1234, s_resp.pc_value)
    bus(0, REG_SP, 0);
    `CHK("sp down", 32'h20, rdq)
    bus(0, REG_STAT, 0);
    `CHK("gie on", 1'b1, rdq[0])
    cpu(7'h20, 16'h0);
    $display("test irq done");
  endtask
  task automatic t_stack;
    cpu(7'h08, 16'h0200);
    grab(2);
    `CHK("push word", 16'ha55a, s_mem.wdata)
    `CHK("push at sp", 8'h20, s_mem.addr)
    cpu(7'h04, 16'h0201);
    grab(1);
    `CHK("pop acc", 8'h5a, s_resp.accumulator)
    `CHK("pop flags", 8'ha5, s_resp.flags)
    $display("test stack done");
  endtask
  task automatic t_save;
    bus(1, REG_PDIR, 32'h01);
    bus(1, REG_PDIE, 32'h03);
    cpu(7'h02, 16'h0300);
    repeat (3) @(posedge core_clk);
    `CHK("save osc", 4'hc, osc_ctl)
    `CHK("save timers", 4'h1, timer_run)
    pin_in[1] <= 1'b1;
    repeat (40) @(posedge core_clk);
    `CHK("output pin no wake", 1'b1, cpu_resp.halt)
    pin_in[0] <= 1'b1;
    wake_span(140, 80);
    `CHK("clock back", 1'b1, osc_ctl.sysclk_en)
    cpu(7'h02, 16'h0301);
    repeat (3) @(posedge core_clk);
    timer_hit[0] <= 1'b1;
    @(posedge core_clk);
    timer_hit[0] <= 1'b0;
    wake_span(140, 80);
    bus(1, REG_WAKE, 32'h4);
    cpu(7'h02, 16'h0302);
    repeat (3) @(posedge core_clk);
    cmp_hit <= 1'b1;
    @(posedge core_clk);
    cmp_hit <= 1'b0;
    repeat (40) @(posedge core_clk);
    `CHK("comparator half armed", 1'b1, cpu_resp.halt)
    bus(1, REG_WAKE, 32'hc);
    cmp_hit <= 1'b1;
    @(posedge core_clk);
    cmp_hit <= 1'b0;
    wake_span(140, 80);
    $display("test save done");
  endtask
  task automatic t_down;
    bus(1, REG_WAKE, 32'h2);
    cpu(7'h01, 16'h0400);
    repeat (3) @(posedge core_clk);
    `CHK("down fast rc", 1'b0, osc_ctl.high_speed_rc_osc)
    `CHK("down slow rc", 1'b0, osc_ctl.low_speed_rc_osc)
    timer_hit[0] <= 1'b1;
    @(posedge core_clk);
    timer_hit[0] <= 1'b0;
    repeat (40) @(posedge core_clk);
    `CHK("sixteen_bit_timer no wake", 1'b1, cpu_resp.halt)
    pin_in[1] <= 1'b0;
    wake_span(60, 80);
    bus(0, REG_SP, 0);
    `CHK("sp kept", 32'h20, rdq)
    bus(1, REG_WAKE, 32'h3);
    timer_src[2] <= TSRC_NANO;
    cpu(7'h01, 16'h0401);
    repeat (3) @(posedge core_clk);
    `CHK("down nano kept", 1'b1, osc_ctl.nano_low_rc_osc)
    timer_hit[2] <= 1'b1;
    @(posedge core_clk);
    timer_hit[2] <= 1'b0;
    wake_span(60, 80);
    $display("test down done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    {avs_read, avs_write, cmp_hit} = 3'h0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    cpu_req = '0;
    src_in = 6'h0;
    pin_in = 8'h0;
    timer_hit = 4'h0;
    timer_src = {TSRC_SYS, TSRC_SYS, TSRC_SYS, TSRC_LS};
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_flags();
    t_irq();
    t_stack();
    t_save();
    t_down();
    finish_test();
  end
endmodule
